/* File: shared/fpa_align_if.sv */
// signals between the add unit control and its alignment shifter
`timescale 1ns/1ps
`include "fpa_consts.svh"
interface fpa_align_if;
  fpa_pkg::fpa_word_type      op_j;       // first operand, as held
  fpa_pkg::fpa_word_type      op_k;       // second operand, as held
  logic                       sel_j;      // first exponent is larger
  logic [`FPA_SHAMT_W-1:0]    shift_amt;  // alignment distance
  logic                       rnd_ref_j;  // reference round bit, first
  logic                       rnd_ref_k;  // reference round bit, second
  logic                       rnd_shf_j;  // shift round bit, first
  logic                       rnd_shf_k;  // shift round bit, second
  fpa_pkg::fpa_opnd_type      ref_op;     // reference operand
  fpa_pkg::fpa_opnd_type      shf_op;     // shifted operand
  modport ctl (output op_j, op_k, sel_j, shift_amt, rnd_ref_j, rnd_ref_k,
               rnd_shf_j, rnd_shf_k, input ref_op, shf_op);
  modport aln (input op_j, op_k, sel_j, shift_amt, rnd_ref_j, rnd_ref_k,
               rnd_shf_j, rnd_shf_k, output ref_op, shf_op);
endinterface // fpa_align_if

/* File: shared/fpa_consts.svh */
// constants for the floating-point add unit
`ifndef FPA_CONSTS_SVH
`define FPA_CONSTS_SVH
`define FPA_WORD_W     60
`define FPA_SIGN_BIT   59
`define FPA_EXP_LSB    48
`define FPA_EXP_MSB    58
`define FPA_EXP_W      11
`define FPA_TEXP_W     12
`define FPA_COEF_W     48
`define FPA_NORM_BIT   47
`define FPA_OPND_W     97
`define FPA_SUM_W      99
`define FPA_SHAMT_W    7
`define FPA_SHIFT_MAX  7'h61
`define FPA_MODE_W     3
`define FPA_MODE_SUB   0
`define FPA_MODE_DP    1
`define FPA_MODE_RND   2
`define FPA_IDX_W      3
`define FPA_EXP_OVF    11'h3ff
`define FPA_EXP_IND    11'h7ff
`define FPA_DP_CORR    12'h030
`define FPA_EXP_ONE    12'h001
`define FPA_EXP_MIN    12'hc01
`define FPA_LATENCY    4
`endif

/* File: shared/fpa_pkg.sv */
// types shared by the floating-point add unit
`include "fpa_consts.svh"
package fpa_pkg;
  typedef logic [`FPA_WORD_W-1:0]        fpa_word_type;
  typedef logic [`FPA_OPND_W-1:0]        fpa_opnd_type;
  typedef logic [`FPA_SUM_W-1:0]         fpa_sum_type;
  typedef logic [`FPA_EXP_W-1:0]         fpa_oexp_type;
  typedef logic signed [`FPA_TEXP_W-1:0] fpa_texp_type;
  typedef enum logic [1:0] {
    fpa_sc_none = 2'h0,
    fpa_sc_ovf  = 2'h1,
    fpa_sc_ind  = 2'h2
  } fpa_special_type;
endpackage

/* File: verification/fpa_cpu_model.sv */
// processor side: go signal after issue and destination register file
`timescale 1ns/1ps
module fpa_cpu_model (
  input  logic                  clk,                   // processor clock
  input  logic                  rst_b,                 // async reset, low
  input  logic                  issue_valid,           // issue strobe
  input  logic                  go_en,                 // op is a floating add
  input  logic                  result_write,          // write strobe
  input  fpa_pkg::fpa_word_type result_word,           // packed result
  input  logic [2:0]            destination_register,  // index written
  output logic                  go_add                 // go, second clock
);
  fpa_pkg::fpa_word_type xreg [8];  // destination registers

  // go stands exactly in the clock after issue, never later
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) go_add <= 1'b0;
    else go_add <= issue_valid && go_en;
  end

  // only the strobe qualifies the word, which moves every op
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < 8; i++) xreg[i] <= 60'h0;
    end else if (result_write) begin
      xreg[destination_register] <= result_word;
    end
  end
endmodule // fpa_cpu_model

/* File: verification/fpa_unit_asserts.sv */
// concurrent checks on the floating-point add unit ports
`timescale 1ns/1ps
`include "fpa_consts.svh"
module fpa_unit_asserts #(
  parameter int IDX_W = `FPA_IDX_W  // width of destination index
) (
  input logic                   clk,                    // processor clock
  input logic                   rst_b,                  // async reset, low
  input logic                   issue_valid,            // issue strobe
  input fpa_pkg::fpa_word_type  first_source_operand,   // first operand
  input fpa_pkg::fpa_word_type  second_source_operand,  // second operand
  input logic [`FPA_MODE_W-1:0] mode_designator,        // operation mode
  input logic [IDX_W-1:0]       issue_dest,             // destination index
  input logic                   go_add,                 // go, second clock
  input logic                   result_write,           // write strobe
  input fpa_pkg::fpa_word_type  result_word,            // packed result
  input logic [IDX_W-1:0]       destination_register,   // index written
  input logic                   indefinite_flag,        // indefinite case
  input logic                   overflow_flag,          // overflow case
  input logic                   underflow_flag,         // underflow case
  input logic                   special_sign            // reference sign
);
  logic ind_any;  // either exponent indefinite
  logic ovf_any;  // either exponent overflow

  // bias removal is invariant under whole-word complement, so mode bit 0 is ignored
  function automatic logic [10:0] unb(input fpa_pkg::fpa_word_type w);
    return w[58:48] ^ (w[59] ? 11'h3ff : 11'h400);
  endfunction
  assign ind_any = (unb(first_source_operand) == 11'h7ff) || (unb(second_source_operand) == 11'h7ff);
  assign ovf_any = (unb(first_source_operand) == 11'h3ff) || (unb(second_source_operand) == 11'h3ff);

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  sequence s_go;
    issue_valid ##1 go_add;
  endsequence
  sequence s_nogo;
    issue_valid ##1 !go_add;
  endsequence

  AST_WR_LAT: assert property (s_go |-> ##2 result_write)
    else $error("write strobe late or missing");
  AST_NO_GO: assert property (s_nogo |-> ##2 !(result_write || indefinite_flag || overflow_flag))
    else $error("write or flag without go");
  AST_DEST: assert property (issue_valid |-> ##3 (destination_register == $past(issue_dest, 3)))
    else $error("destination index does not follow its op");
  AST_IND: assert property (issue_valid && ind_any ##1 go_add |-> ##2 indefinite_flag)
    else $error("indefinite operand not flagged");
  AST_OVF: assert property (issue_valid && ovf_any && !ind_any ##1 go_add |-> ##2 overflow_flag)
    else $error("overflow operand not flagged");
  AST_IND_PRI: assert property (indefinite_flag |-> !overflow_flag)
    else $error("overflow raised beside indefinite");
  AST_SPC_ZERO: assert property ((indefinite_flag || overflow_flag) |-> (result_write && result_word == '0))
    else $error("special case output not blocked");
  AST_UNF: assert property (underflow_flag |-> (result_write && !indefinite_flag && !overflow_flag))
    else $error("underflow flag out of place");
  AST_SP_CLEAN: assert property (issue_valid && !ind_any && !ovf_any && !mode_designator[1] ##1 go_add
      |-> ##2 !(indefinite_flag || overflow_flag || underflow_flag))
    else $error("flag raised on plain single op");
endmodule // fpa_unit_asserts

bind fpa_unit fpa_unit_asserts #(.IDX_W(IDX_W)) fpa_unit_asserts_inst (.clk(clk), .rst_b(rst_b),
  .issue_valid(issue_valid), .first_source_operand(first_source_operand),
  .second_source_operand(second_source_operand), .mode_designator(mode_designator),
  .issue_dest(issue_dest), .go_add(go_add), .result_write(result_write),
  .result_word(result_word), .destination_register(destination_register),
  .indefinite_flag(indefinite_flag), .overflow_flag(overflow_flag),
  .underflow_flag(underflow_flag), .special_sign(special_sign));

/* File: verification/tb_fpa_unit.sv */
// self-checking bench for the floating-point add unit
`timescale 1ns/1ps
module tb_fpa_unit;
  localparam logic [10:0] e0 = 11'h410;  // unbiased exponent 16
  logic                  clk, rst_b, issue_valid, go_en, go_add;
  logic                  result_write, indefinite_flag, overflow_flag, underflow_flag;
  logic                  special_sign;
  fpa_pkg::fpa_word_type first_source_operand, second_source_operand, result_word;
  logic [2:0]            mode_designator, issue_dest, destination_register;
  int                    error_cnt, n_tests;

  fpa_unit fpa_unit_inst (.clk(clk), .rst_b(rst_b), .issue_valid(issue_valid),
    .first_source_operand(first_source_operand), .second_source_operand(second_source_operand),
    .mode_designator(mode_designator), .issue_dest(issue_dest), .go_add(go_add),
    .result_write(result_write), .result_word(result_word),
    .destination_register(destination_register), .indefinite_flag(indefinite_flag),
    .overflow_flag(overflow_flag), .underflow_flag(underflow_flag), .special_sign(special_sign));
  fpa_cpu_model fpa_cpu_model_inst (.clk(clk), .rst_b(rst_b), .issue_valid(issue_valid),
    .go_en(go_en), .result_write(result_write), .result_word(result_word),
    .destination_register(destination_register), .go_add(go_add));

  always #2.5 clk = ~clk;

  // positive word from biased exponent and coefficient
  function automatic fpa_pkg::fpa_word_type pk(input logic [10:0] e, input logic [47:0] c);
    return {1'b0, e, c};
  endfunction
  task automatic chk_bit(input string n, input logic e, input logic g);
    n_tests++;
    if (g !== e) begin error_cnt++; $display("mismatch %s expected %b seen %b", n, e, g); end
  endtask
  task automatic chk_word(input string n, input fpa_pkg::fpa_word_type e, input fpa_pkg::fpa_word_type g);
    n_tests++;
    if (g !== e) begin error_cnt++; $display("mismatch %s expected %h seen %h", n, e, g); end
  endtask
  task automatic chk_idx(input string n, input logic [2:0] e, input logic [2:0] g);
    n_tests++;
    if (g !== e) begin error_cnt++; $display("mismatch %s expected %h seen %h", n, e, g); end
  endtask
  // one issue cycle, inputs change at the falling edge
  task automatic issue(input fpa_pkg::fpa_word_type j, k, input logic [2:0] m, d, input logic g);
    issue_valid = 1'b1;
    first_source_operand = j;
    second_source_operand = k;
    mode_designator = m;
    issue_dest = d;
    go_en = g;
    @(negedge clk);
  endtask
  // f = {write, indefinite, overflow, underflow}; word skipped on underflow
  task automatic check(input fpa_pkg::fpa_word_type ew, input logic [3:0] f, input logic [2:0] d);
    chk_bit("write", f[3], result_write);
    chk_bit("indefinite", f[2], indefinite_flag);
    chk_bit("overflow", f[1], overflow_flag);
    chk_bit("underflow", f[0], underflow_flag);
    if (!f[0]) chk_word("word", ew, result_word);
    if (f[3]) chk_idx("dest", d, destination_register);
    @(negedge clk);
    if (!f[0]) chk_word("xreg", f[3] ? ew : 60'h0, fpa_cpu_model_inst.xreg[d]);
  endtask
  // result stands in the fourth clock counting the issue clock
  task automatic run_op(input fpa_pkg::fpa_word_type j, k, input logic [2:0] m, d, input logic g,
                        input fpa_pkg::fpa_word_type ew, input logic [3:0] f);
    issue(j, k, m, d, g);
    issue_valid = 1'b0;
    repeat (2) @(negedge clk);
    check(ew, f, d);
  endtask
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // watchdog sized well above the 63 cycles of the sequence
  initial begin
    #20000;
    error_cnt++;
    summarize();
  end

  initial begin
    clk = 1'b0; rst_b = 1'b0; issue_valid = 1'b0; go_en = 1'b0;
    first_source_operand = 60'h0; second_source_operand = 60'h0;
    mode_designator = 3'h0; issue_dest = 3'h0; error_cnt = 0; n_tests = 0;
    repeat (10) @(negedge clk);
    chk_bit("write_rst", 1'b0, result_write);
    chk_word("word_rst", 60'h0, result_word);
    rst_b = 1'b1;
    run_op(pk(e0, 48'h100), pk(e0, 48'h200), 3'h0, 3'h1, 1'b1, pk(e0, 48'h300), 4'h8);
    chk_bit("sign", 1'b0, special_sign);
    run_op(pk(e0, 48'h300), pk(e0, 48'h100), 3'h1, 3'h2, 1'b1, pk(e0, 48'h200), 4'h8);
    // equal exponents: the inverted second operand is the reference, so its sign shows
    chk_bit("sign", 1'b1, special_sign);
    // unbiased -32 packs as ones-complement 0x7df with bit 10 flipped
    run_op(pk(e0, 48'h100), pk(e0, 48'h200), 3'h2, 3'h3, 1'b1, pk(11'h3df, 48'h0), 4'h8);
    run_op(pk(e0, 48'h100), pk(e0, 48'h200), 3'h6, 3'h3, 1'b1,
           pk(11'h3df, 48'h8000_0000_0000), 4'h8);
    run_op(pk(e0, 48'h8000_0000_0000), pk(e0, 48'h8000_0000_0001), 3'h4, 3'h4, 1'b1,
           pk(11'h411, 48'h8000_0000_0001), 4'h8);
    run_op(pk(e0 + 11'h4, 48'h100), pk(e0, 48'h100), 3'h0, 3'h5, 1'b1,
           pk(e0 + 11'h4, 48'h110), 4'h8);
    run_op(pk(e0, 48'h100), pk(e0 + 11'h4, 48'h200), 3'h0, 3'h5, 1'b1,
           pk(e0 + 11'h4, 48'h210), 4'h8);
    run_op(~pk(e0, 48'h100), ~pk(e0, 48'h200), 3'h0, 3'h6, 1'b1, ~pk(e0, 48'h300), 4'h8);
    chk_bit("sign", 1'b1, special_sign);
    run_op(pk(11'h7ff, 48'h0), pk(e0, 48'h1), 3'h0, 3'h1, 1'b1, 60'h0, 4'ha);
    run_op(pk(11'h3ff, 48'h0), pk(11'h7ff, 48'h0), 3'h1, 3'h2, 1'b1, 60'h0, 4'hc);
    run_op(pk(e0, 48'h100), pk(e0, 48'h200), 3'h0, 3'h7, 1'b0, pk(e0, 48'h300), 4'h0);
    run_op(pk(11'h003, 48'h100), pk(11'h003, 48'h100), 3'h2, 3'h0, 1'b1, 60'h0, 4'h9);
    // back-to-back issue: two results in consecutive clocks
    issue(pk(e0, 48'h1), pk(e0, 48'h2), 3'h0, 3'h1, 1'b1);
    issue(pk(e0 + 11'h1, 48'h2), pk(e0, 48'h2), 3'h0, 3'h2, 1'b1);
    issue_valid = 1'b0;
    @(negedge clk);
    check(pk(e0, 48'h3), 4'h8, 3'h1);
    check(pk(e0 + 11'h1, 48'h3), 4'h8, 3'h2);
    summarize();
  end
endmodule // tb_fpa_unit

/* File: verilog/fpa_align.sv */
// operand selection, round insertion and right-shift alignment
`timescale 1ns/1ps
`include "fpa_consts.svh"
module fpa_align (
  fpa_align_if.aln bus   // operands in, aligned operands out
);

  // coefficient in the upper half, round bit atop the lower half, sign copied below it
  function automatic fpa_pkg::fpa_opnd_type build(
    input fpa_pkg::fpa_word_type w,
    input logic                  rnd
  );
    logic s;
    s = w[`FPA_SIGN_BIT];
    build = {s, w[`FPA_COEF_W-1:0], rnd ? ~s : s,
             {(`FPA_OPND_W-`FPA_COEF_W-2){s}}};
  endfunction

  fpa_pkg::fpa_opnd_type shf_raw;

  // larger exponent gives the reference; ties keep the second operand
  always_comb begin
    if (bus.sel_j) begin
      bus.ref_op = build(bus.op_j, bus.rnd_ref_j);
      shf_raw    = build(bus.op_k, bus.rnd_shf_k);
    end else begin
      bus.ref_op = build(bus.op_k, bus.rnd_ref_k);
      shf_raw    = build(bus.op_j, bus.rnd_shf_j);
    end
  end

  // arithmetic shift extends the sign above; round bit travels along
  always_comb begin
    bus.shf_op = fpa_pkg::fpa_opnd_type'($signed(shf_raw) >>> bus.shift_amt);
  end

endmodule // fpa_align

/* File: verilog/fpa_unit.sv */
// four-clock floating-point add and subtract unit
`timescale 1ns/1ps
`include "fpa_consts.svh"
module fpa_unit #(
  parameter int IDX_W = `FPA_IDX_W   // width of destination index
) (
  input  logic                    clk,                    // processor clock
  input  logic                    rst_b,                  // async reset, low
  input  logic                    issue_valid,            // instruction issues
  input  fpa_pkg::fpa_word_type   first_source_operand,   // first operand
  input  fpa_pkg::fpa_word_type   second_source_operand,  // second operand
  input  logic [`FPA_MODE_W-1:0]  mode_designator,        // operation mode
  input  logic [IDX_W-1:0]        issue_dest,             // destination index
  input  logic                    go_add,                 // go, second clock
  output logic                    result_write,           // write strobe
  output fpa_pkg::fpa_word_type   result_word,            // packed result
  output logic [IDX_W-1:0]        destination_register,   // index written
  output logic                    indefinite_flag,        // indefinite case
  output logic                    overflow_flag,          // overflow case
  output logic                    underflow_flag,         // exponent underflow
  output logic                    special_sign            // reference sign
);

  // remove or restore bias; the same inversion works both ways
  function automatic fpa_pkg::fpa_oexp_type bias_flip(
    input logic                  s,
    input fpa_pkg::fpa_oexp_type e
  );
    bias_flip = s ? {e[`FPA_EXP_W-1], ~e[`FPA_EXP_W-2:0]}
                  : {~e[`FPA_EXP_W-1], e[`FPA_EXP_W-2:0]};
  endfunction

  // ones-complement exponent to two's complement for the subtractor
  function automatic fpa_pkg::fpa_texp_type oc_to_tc(
    input fpa_pkg::fpa_oexp_type e
  );
    oc_to_tc = e[`FPA_EXP_W-1] ? $signed({1'b1, e}) + $signed(`FPA_EXP_ONE)
                               : $signed({1'b0, e});
  endfunction

  // back to ones-complement form for packing
  function automatic fpa_pkg::fpa_oexp_type tc_to_oc(
    input fpa_pkg::fpa_texp_type t
  );
    fpa_pkg::fpa_texp_type m;
    m = t - $signed(`FPA_EXP_ONE);
    tc_to_oc = t[`FPA_TEXP_W-1] ? m[`FPA_EXP_W-1:0] : t[`FPA_EXP_W-1:0];
  endfunction

  // operand is normalised when its top coefficient bit differs from sign
  function automatic logic is_norm(input fpa_pkg::fpa_word_type w);
    is_norm = w[`FPA_NORM_BIT] ^ w[`FPA_SIGN_BIT];
  endfunction

  // ---------------- first clock: input registers ----------------
  logic                  v1_r;
  fpa_pkg::fpa_word_type op_j1_r;
  fpa_pkg::fpa_word_type op_k1_r;
  logic                  dp1_r;
  logic                  rnd1_r;
  logic [IDX_W-1:0]      dest1_r;

  // issue valid tracks every clock so back-to-back issues pipeline
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      v1_r <= 1'b0;
    end else begin
      v1_r <= issue_valid;
    end
  end

  // operands and mode held only when an instruction issues
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      op_j1_r <= '0;
      op_k1_r <= '0;
      dp1_r   <= 1'b0;
      rnd1_r  <= 1'b0;
      dest1_r <= '0;
    end else if (issue_valid) begin
      op_j1_r <= first_source_operand;
      op_k1_r <= mode_designator[`FPA_MODE_SUB] ?
                 ~second_source_operand : second_source_operand;
      dp1_r   <= mode_designator[`FPA_MODE_DP];
      rnd1_r  <= mode_designator[`FPA_MODE_RND];
      dest1_r <= issue_dest;
    end
  end

  // ---------------- second clock: exponents and alignment ----------------
  fpa_pkg::fpa_oexp_type     ue_j;
  fpa_pkg::fpa_oexp_type     ue_k;
  fpa_pkg::fpa_texp_type     te_j;
  fpa_pkg::fpa_texp_type     te_k;
  fpa_pkg::fpa_texp_type     diff;
  fpa_pkg::fpa_texp_type     mag;
  logic                      sel_j;
  logic                      ovf_j;
  logic                      ovf_k;
  logic                      ind_j;
  logic                      ind_k;
  logic                      rnd_shift;
  logic [`FPA_SHAMT_W-1:0]   shamt;
  fpa_pkg::fpa_special_type  spec;

  fpa_align_if al_if ();

  // unbias both exponents, then test for the reserved values
  always_comb begin
    ue_j  = bias_flip(op_j1_r[`FPA_SIGN_BIT], op_j1_r[`FPA_EXP_MSB:`FPA_EXP_LSB]);
    ue_k  = bias_flip(op_k1_r[`FPA_SIGN_BIT], op_k1_r[`FPA_EXP_MSB:`FPA_EXP_LSB]);
    ovf_j = (ue_j == `FPA_EXP_OVF);
    ovf_k = (ue_k == `FPA_EXP_OVF);
    ind_j = (ue_j == `FPA_EXP_IND);
    ind_k = (ue_k == `FPA_EXP_IND);
  end

  // indefinite outranks overflow whichever operand carries it
  always_comb begin
    if (ind_j || ind_k) begin
      spec = fpa_pkg::fpa_sc_ind;
    end else if (ovf_j || ovf_k) begin
      spec = fpa_pkg::fpa_sc_ovf;
    end else begin
      spec = fpa_pkg::fpa_sc_none;
    end
  end

  // exponent subtractor: sign of difference and shift distance
  always_comb begin
    te_j  = oc_to_tc(ue_j);
    te_k  = oc_to_tc(ue_k);
    diff  = te_j - te_k;
    sel_j = !diff[`FPA_TEXP_W-1] && (diff != '0);
    mag   = diff[`FPA_TEXP_W-1] ? -diff : diff;
    // distances beyond the operand width all give a pure sign word
    if (mag > $signed({5'h00, `FPA_SHIFT_MAX})) begin
      shamt = `FPA_SHIFT_MAX;
    end else begin
      shamt = mag[`FPA_SHAMT_W-1:0];
    end
  end

  // round bits for both operands formed ahead of the selection
  always_comb begin
    rnd_shift = rnd1_r &&
                ((is_norm(op_j1_r) && is_norm(op_k1_r)) ||
                 (op_j1_r[`FPA_SIGN_BIT] != op_k1_r[`FPA_SIGN_BIT]));
    al_if.rnd_ref_j = rnd1_r;
    al_if.rnd_ref_k = rnd1_r;
    al_if.rnd_shf_j = rnd_shift;
    al_if.rnd_shf_k = rnd_shift;
    al_if.op_j      = op_j1_r;
    al_if.op_k      = op_k1_r;
    al_if.sel_j     = sel_j;
    al_if.shift_amt = shamt;
  end

  fpa_align u_align (
    .bus (al_if.aln)
  );

  fpa_pkg::fpa_opnd_type    ref2_r;
  fpa_pkg::fpa_opnd_type    shf2_r;
  fpa_pkg::fpa_texp_type    exp2_r;
  fpa_pkg::fpa_special_type spec2_r;
  logic                     ref_sign2_r;
  logic                     dp2_r;
  logic                     v2_r;
  logic                     go2_r;
  logic [IDX_W-1:0]         dest2_r;

  // go is only meaningful in the second clock of a live operation
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      v2_r  <= 1'b0;
      go2_r <= 1'b0;
    end else begin
      v2_r  <= v1_r;
      go2_r <= v1_r && go_add;
    end
  end

  // aligned operands, kept exponent and special status
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ref2_r      <= '0;
      shf2_r      <= '0;
      exp2_r      <= '0;
      spec2_r     <= fpa_pkg::fpa_sc_none;
      ref_sign2_r <= 1'b0;
      dp2_r       <= 1'b0;
      dest2_r     <= '0;
    end else begin
      ref2_r      <= al_if.ref_op;
      shf2_r      <= al_if.shf_op;
      exp2_r      <= sel_j ? te_j : te_k;
      spec2_r     <= spec;
      ref_sign2_r <= sel_j ? op_j1_r[`FPA_SIGN_BIT] : op_k1_r[`FPA_SIGN_BIT];
      dp2_r       <= dp1_r;
      dest2_r     <= dest1_r;
    end
  end

  // ---------------- third clock: sum and result packing ----------------
  fpa_pkg::fpa_sum_type     ext_ref;
  fpa_pkg::fpa_sum_type     ext_shf;
  logic [`FPA_SUM_W:0]      raw;
  fpa_pkg::fpa_sum_type     sum;
  logic                     c_ovf;
  logic                     res_sign;
  logic [`FPA_COEF_W-1:0]   coef;
  fpa_pkg::fpa_texp_type    res_exp;
  logic                     unf;
  fpa_pkg::fpa_word_type    packed_word;

  // ones-complement add: carry out wraps round into the bottom
  always_comb begin
    ext_ref = {{2{ref2_r[`FPA_OPND_W-1]}}, ref2_r};
    ext_shf = {{2{shf2_r[`FPA_OPND_W-1]}}, shf2_r};
    raw     = {1'b0, ext_ref} + {1'b0, ext_shf};
    sum     = raw[`FPA_SUM_W-1:0] + {{(`FPA_SUM_W-1){1'b0}}, raw[`FPA_SUM_W]};
  end

  // like signs that flip bit 96 mean the coefficient overflowed
  always_comb begin
    c_ovf    = (ref2_r[`FPA_OPND_W-1] == shf2_r[`FPA_OPND_W-1]) &&
               (sum[`FPA_OPND_W-1] != ref2_r[`FPA_OPND_W-1]);
    res_sign = sum[`FPA_SUM_W-1];
  end

  // pick upper or lower half, one bit higher on overflow
  always_comb begin
    if (dp2_r) begin
      coef = c_ovf ? sum[`FPA_COEF_W:1] : sum[`FPA_COEF_W-1:0];
    end else begin
      coef = c_ovf ? sum[`FPA_OPND_W-1:`FPA_COEF_W+1]
                   : sum[`FPA_OPND_W-2:`FPA_COEF_W];
    end
  end

  // exponent correction; dp underflow is only flagged, not clamped
  always_comb begin
    res_exp = exp2_r;
    if (c_ovf) begin
      res_exp = res_exp + $signed(`FPA_EXP_ONE);
    end
    if (dp2_r) begin
      res_exp = res_exp - $signed(`FPA_DP_CORR);
    end
    unf         = dp2_r && (res_exp < $signed(`FPA_EXP_MIN));
    packed_word = {res_sign, bias_flip(res_sign, tc_to_oc(res_exp)), coef};
  end

  logic                  wr_r;
  fpa_pkg::fpa_word_type word_r;
  logic [IDX_W-1:0]      dest_r;
  logic                  ind_r;
  logic                  ovf_r;
  logic                  unf_r;
  logic                  sign_r;

  // write strobe in the fourth clock, gated by the held go
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wr_r   <= 1'b0;
      dest_r <= '0;
    end else begin
      wr_r   <= v2_r && go2_r;
      dest_r <= dest2_r;
    end
  end

  // special cases zero the word; the processor builds their result
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      word_r <= '0;
    end else if (spec2_r != fpa_pkg::fpa_sc_none) begin
      word_r <= '0;
    end else begin
      word_r <= packed_word;
    end
  end

  // flags pulse with the write so an ungated result raises nothing
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ind_r  <= 1'b0;
      ovf_r  <= 1'b0;
      unf_r  <= 1'b0;
      sign_r <= 1'b0;
    end else begin
      ind_r  <= v2_r && go2_r && (spec2_r == fpa_pkg::fpa_sc_ind);
      ovf_r  <= v2_r && go2_r && (spec2_r == fpa_pkg::fpa_sc_ovf);
      unf_r  <= v2_r && go2_r && unf && (spec2_r == fpa_pkg::fpa_sc_none);
      sign_r <= ref_sign2_r;
    end
  end

  // outputs straight from the final flip-flops
  assign result_write         = wr_r;
  assign result_word          = word_r;
  assign destination_register = dest_r;
  assign indefinite_flag      = ind_r;
  assign overflow_flag        = ovf_r;
  assign underflow_flag       = unf_r;
  assign special_sign         = sign_r;

endmodule // fpa_unit
